// file: rtl/wit_ctrl.sv
// Controller end: Avalon-MM slave that issues timer bus cycles and pins.
// Assumes an Avalon master on clk; the timer answers reads in one cycle.
`timescale 1ns/100ps
module wit_ctrl
    import wit_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    wit_link_if.ctl link
);

    typedef struct packed {
        logic resp;
        logic [31:0] rdReg;
        logic [15:0] wdata;
        logic [15:0] addr;
        logic word;
        logic wr;
        logic rd;
        logic busy;
        logic [15:0] result;
        logic hardRst;
        logic hwStby;
        logic stbyPulse;
        logic wakePulse;
    } wit_ctrl_state_t;

    wit_ctrl_state_t c_q;
    wit_ctrl_state_t c_d;
    logic req;
    logic stall;
    logic accept;

    // A new command waits while the previous bus cycle is open
    assign req = avsRead || avsWrite;
    assign stall = avsWrite && avsAddress == WIT_AV_CMD && c_q.busy;
    assign accept = req && c_q.resp && !stall;
    assign avsWaitRequest = req && !(c_q.resp && !stall);
    assign avsReadData = c_q.rdReg;

    always_comb
    begin
        c_d = c_q;
        c_d.wr = 1'b0;
        c_d.rd = 1'b0;
        c_d.stbyPulse = 1'b0;
        c_d.wakePulse = 1'b0;
        c_d.resp = req && !accept;

        // ------------------------------------------------------------
        // Read data prepared in the cycle before the answer
        // ------------------------------------------------------------
        if (avsRead && !c_q.resp)
        begin
            unique case (avsAddress)
                WIT_AV_RDATA: c_d.rdReg = {c_q.busy, 15'h0000, c_q.result};
                WIT_AV_PINS: c_d.rdReg = {25'h000_0000, !link.rstOutN,
                    link.chipRst, link.intervalIrq, 2'h0, c_q.hwStby,
                    c_q.hardRst};
                WIT_AV_WDATA: c_d.rdReg = {16'h0000, c_q.wdata};
                default: c_d.rdReg = 32'h0000_0000;
            endcase
        end

        if (c_q.wr)
            c_d.busy = 1'b0;
        if (link.rdValid && c_q.busy)
        begin
            c_d.result = link.rdData;
            c_d.busy = 1'b0;
        end

        if (accept && avsWrite)
        begin
            unique case (avsAddress)
                WIT_AV_CMD:
                begin
                    // Password word is passed through as given
                    c_d.addr = avsWriteData[15:0];
                    c_d.word = avsWriteData[WIT_CMD_WORD];
                    c_d.wr = avsWriteData[WIT_CMD_WRITE];
                    c_d.rd = !avsWriteData[WIT_CMD_WRITE];
                    c_d.busy = 1'b1;
                end
                WIT_AV_WDATA: c_d.wdata = avsWriteData[15:0];
                WIT_AV_PINS:
                begin
                    c_d.hardRst = avsWriteData[0];
                    c_d.hwStby = avsWriteData[1];
                    c_d.stbyPulse = avsWriteData[2];
                    c_d.wakePulse = avsWriteData[3];
                end
                default: c_d.hardRst = c_q.hardRst;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            c_q <= '0;
        else
            c_q <= c_d;
    end

    assign link.addr = c_q.addr;
    assign link.wrData = c_q.wdata;
    assign link.wordAcc = c_q.word;
    assign link.wr = c_q.wr;
    assign link.rd = c_q.rd;
    assign link.hardRstN = !c_q.hardRst;
    assign link.hwStandby = c_q.hwStby;
    assign link.standbyReq = c_q.stbyPulse;
    assign link.wakeNmi = c_q.wakePulse;

endmodule : wit_ctrl

// file: rtl/wit_link_if.sv
// Link between the timer and the controller that plays the CPU.
// Assumes both ends share one clock; no clocking block.
`timescale 1ns/100ps
interface wit_link_if;
    logic [15:0] addr;
    logic [15:0] wrData;
    logic wordAcc;
    logic wr;
    logic rd;
    logic [15:0] rdData;
    logic rdValid;
    logic hardRstN;
    logic hwStandby;
    logic standbyReq;
    logic wakeNmi;
    logic intervalIrq;
    logic chipRst;
    logic rstOutN;

    modport dev (
        input addr, wrData, wordAcc, wr, rd, hardRstN, hwStandby,
        input standbyReq, wakeNmi,
        output rdData, rdValid, intervalIrq, chipRst, rstOutN
    );
    modport ctl (
        output addr, wrData, wordAcc, wr, rd, hardRstN, hwStandby,
        output standbyReq, wakeNmi,
        input rdData, rdValid, intervalIrq, chipRst, rstOutN
    );
endinterface : wit_link_if

// file: rtl/wit_pkg.sv
// Shared constants and types for the watchdog / interval timer pair.
// Assumes one 10 MHz clock and a synchronous active-high reset.
package wit_pkg;

    // ------------------------------------------------------------
    // Timer-side register map and field layout
    // ------------------------------------------------------------
    localparam logic [15:0] WIT_ADDR_CSR = 16'hff10;
    localparam logic [15:0] WIT_ADDR_CNT = 16'hff11;
    localparam logic [15:0] WIT_ADDR_RST = 16'hff1f;
    localparam logic [7:0] WIT_PW_CNT = 8'h5a;
    localparam logic [7:0] WIT_PW_CSR = 8'ha5;
    localparam logic [7:0] WIT_CSR_RESET = 8'h18;
    localparam logic [7:0] WIT_CNT_RESET = 8'h00;
    localparam logic [7:0] WIT_RST_RESET = 8'h3f;
    localparam logic [7:0] WIT_CNT_MAX = 8'hff;
    localparam int WIT_BIT_OVF = 7;
    localparam int WIT_BIT_MODE = 6;
    localparam int WIT_BIT_RUN = 5;
    localparam int WIT_BIT_OUTEN = 6;
    localparam logic [1:0] WIT_CSR_ONES = 2'h3;
    localparam logic [5:0] WIT_RST_ONES = 6'h3f;

    // Prescaler masks for divide by 2,32,64,128,256,512,2048,4096
    localparam logic [11:0] WIT_PRE_MASK [8] = '{
        12'h001, 12'h01f, 12'h03f, 12'h07f,
        12'h0ff, 12'h1ff, 12'h7ff, 12'hfff};

    // ------------------------------------------------------------
    // Reset pulse lengths in system clock cycles
    // ------------------------------------------------------------
    localparam logic [9:0] WIT_INT_RST_CYC = 10'h206;
    localparam logic [7:0] WIT_OUT_RST_CYC = 8'h84;

    // ------------------------------------------------------------
    // Controller register map (Avalon byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] WIT_AV_CMD = 5'h00;
    localparam logic [4:0] WIT_AV_WDATA = 5'h04;
    localparam logic [4:0] WIT_AV_RDATA = 5'h08;
    localparam logic [4:0] WIT_AV_PINS = 5'h0c;
    localparam int WIT_CMD_WRITE = 16;
    localparam int WIT_CMD_WORD = 17;

    typedef enum logic [2:0] {
        WIT_ST_RUN = 3'h1,
        WIT_ST_STBY = 3'h2,
        WIT_ST_WAKE = 3'h4
    } wit_state_t;

endpackage : wit_pkg

// file: rtl/wit_timer.sv
// Watchdog / interval timer: 8-bit counter, prescaler, password writes.
// Assumes the link partner runs on clk and issues one-cycle requests.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/100ps
module wit_timer
    import wit_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    wit_link_if.dev link,
    output logic inStandby,
    output logic standbyExit
);

    typedef struct packed {
        wit_state_t st;
        logic [11:0] pre;
        logic [7:0] cnt;
        logic ovf;
        logic ovfSeen;
        logic mode;
        logic run;
        logic [2:0] cks;
        logic wdRst;
        logic outEn;
        logic [9:0] intCnt;
        logic [7:0] outCnt;
        logic [15:0] rdData;
        logic rdValid;
        logic exitPulse;
    } wit_timer_state_t;

    wit_timer_state_t s_q;
    wit_timer_state_t s_d;

    // ------------------------------------------------------------
    // Read view
    // ------------------------------------------------------------
    function automatic logic [7:0] readByte(input wit_timer_state_t s,
                                            input logic [15:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == WIT_ADDR_CSR)
            v = {s.ovf, s.mode, s.run, WIT_CSR_ONES, s.cks};
        else if (a == WIT_ADDR_CNT)
            v = s.cnt;
        else if (a == WIT_ADDR_RST)
            v = {s.wdRst, s.outEn, WIT_RST_ONES};
        return v;
    endfunction : readByte

    logic tick;
    logic counting;
    logic wrWord;
    logic cntWr;
    logic csrWr;
    logic rstWr;
    logic ovfEv;
    logic csrRead;
    logic [7:0] hi;
    logic [7:0] lo;

    assign hi = link.wrData[15:8];
    assign lo = link.wrData[7:0];

    always_comb
    begin
        s_d = s_q;
        s_d.rdValid = 1'b0;
        s_d.exitPulse = 1'b0;
        s_d.pre = s_q.pre + 12'h001;
        ovfEv = 1'b0;
        tick = (s_q.pre & WIT_PRE_MASK[s_q.cks]) ==
               WIT_PRE_MASK[s_q.cks];
        counting = (s_q.run && s_q.st == WIT_ST_RUN) ||
                   s_q.st == WIT_ST_WAKE;
        // Byte writes and unknown passwords fall through untouched
        wrWord = link.wr && link.wordAcc && s_q.intCnt == 10'h000;
        cntWr = wrWord && link.addr == WIT_ADDR_CSR &&
                hi == WIT_PW_CNT;
        csrWr = wrWord && link.addr == WIT_ADDR_CSR &&
                hi == WIT_PW_CSR;
        rstWr = wrWord && link.addr == WIT_ADDR_RST;
        // Only a read that returns the control byte arms the clear
        csrRead = link.rd && link.addr == WIT_ADDR_CSR;

        // ------------------------------------------------------------
        // Reads: byte in low lane, word as high/low pair
        // ------------------------------------------------------------
        if (link.rd)
        begin
            s_d.rdValid = 1'b1;
            if (link.wordAcc)
                s_d.rdData = {readByte(s_q, link.addr),
                              readByte(s_q, link.addr | 16'h0001)};
            else
                s_d.rdData = {8'h00, readByte(s_q, link.addr)};
        end
        if (csrRead && s_q.ovf)
            s_d.ovfSeen = 1'b1;

        // ------------------------------------------------------------
        // Counter
        // ------------------------------------------------------------
        if (counting && tick)
        begin
            s_d.cnt = s_q.cnt + 8'h01;
            ovfEv = s_q.cnt == WIT_CNT_MAX;
        end
        if (cntWr)
        begin
            s_d.cnt = lo;
            ovfEv = 1'b0;
        end

        if (csrWr)
        begin
            s_d.mode = lo[WIT_BIT_MODE];
            s_d.run = lo[WIT_BIT_RUN];
            s_d.cks = lo[2:0];
            if (!lo[WIT_BIT_OVF] && s_q.ovfSeen)
            begin
                s_d.ovf = 1'b0;
                s_d.ovfSeen = 1'b0;
            end
        end
        if (!s_d.run && s_q.st == WIT_ST_RUN)
            s_d.cnt = WIT_CNT_RESET;

        if (rstWr && hi == WIT_PW_CSR && lo == 8'h00)
            s_d.wdRst = 1'b0;
        if (rstWr && hi == WIT_PW_CNT)
            s_d.outEn = lo[WIT_BIT_OUTEN];

        // Set wins over a software clear in the same cycle
        if (ovfEv && s_q.st == WIT_ST_RUN)
        begin
            s_d.ovf = 1'b1;
            if (s_q.mode)
            begin
                s_d.wdRst = 1'b1;
                s_d.intCnt = WIT_INT_RST_CYC;
                s_d.outCnt = s_q.outEn ? WIT_OUT_RST_CYC : 8'h00;
            end
        end

        // ------------------------------------------------------------
        // Standby sequencing
        // ------------------------------------------------------------
        unique case (s_q.st)
            WIT_ST_RUN:
            begin
                // A running counter blocks standby entry
                if (link.standbyReq && !s_q.run)
                begin
                    s_d.st = WIT_ST_STBY;
                    s_d.ovf = 1'b0;
                    s_d.mode = 1'b0;
                    s_d.run = 1'b0;
                    s_d.cnt = WIT_CNT_RESET;
                end
            end
            WIT_ST_STBY:
            begin
                if (link.wakeNmi)
                    s_d.st = WIT_ST_WAKE;
            end
            WIT_ST_WAKE:
            begin
                // Oscillator settled once the count wraps
                if (ovfEv)
                begin
                    s_d.st = WIT_ST_RUN;
                    s_d.exitPulse = 1'b1;
                end
            end
        endcase

        // ------------------------------------------------------------
        // Own reset hold: control state and overflow flag cleared, reset flag kept
        // ------------------------------------------------------------
        if (s_q.intCnt != 10'h000)
        begin
            s_d.intCnt = s_q.intCnt - 10'h001;
            s_d.ovf = 1'b0;
            s_d.ovfSeen = 1'b0;
            s_d.mode = 1'b0;
            s_d.run = 1'b0;
            s_d.cks = 3'h0;
            s_d.cnt = WIT_CNT_RESET;
            s_d.st = WIT_ST_RUN;
        end
        if (s_q.outCnt != 8'h00)
            s_d.outCnt = s_q.outCnt - 8'h01;

        if (link.hwStandby)
        begin
            s_d.ovf = 1'b0;
            s_d.ovfSeen = 1'b0;
            s_d.mode = 1'b0;
            s_d.run = 1'b0;
            s_d.cks = 3'h0;
            s_d.cnt = WIT_CNT_RESET;
            s_d.st = WIT_ST_RUN;
        end
    end

    // ------------------------------------------------------------
    // State register; the reset pin outranks a watchdog reset
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst || !link.hardRstN)
        begin
            s_q <= '0;
            s_q.st <= WIT_ST_RUN;
            s_q.cnt <= WIT_CNT_RESET;
            s_q.wdRst <= WIT_RST_RESET[7];
            s_q.outEn <= WIT_RST_RESET[6];
            s_q.mode <= WIT_CSR_RESET[6];
            s_q.run <= WIT_CSR_RESET[5];
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign link.rdData = s_q.rdData;
    assign link.rdValid = s_q.rdValid;
    assign link.intervalIrq = s_q.ovf;
    assign link.chipRst = s_q.intCnt != 10'h000;
    assign link.rstOutN = s_q.outCnt == 8'h00;
    assign inStandby = s_q.st != WIT_ST_RUN;
    assign standbyExit = s_q.exitPulse;

endmodule : wit_timer

// file: testbench/watchdog_interval_timer_tb.sv
// Bench: timer and controller on one link, driven over Avalon.
// Assumes package and interface are compiled first.
`timescale 1ns/100ps
module watchdog_interval_timer_tb
    import wit_pkg::*;
;
    logic clk;
    logic rst;
    logic [4:0] avsAddress;
    logic avsRead;
    logic avsWrite;
    logic [31:0] avsWriteData;
    logic [31:0] avsReadData;
    logic avsWaitRequest;
    logic inStandby;
    logic standbyExit;
    int errors;
    int compares;

    wit_link_if link();
    wit_timer u_wit_timer (.clk(clk), .rst(rst), .link(link),
        .inStandby(inStandby), .standbyExit(standbyExit));
    wit_ctrl u_wit_ctrl (.clk(clk), .rst(rst), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .link(link));
    wit_link_monitor u_mon (.clk(clk), .rst(rst), .addr(link.addr),
        .wordAcc(link.wordAcc), .rd(link.rd), .rdData(link.rdData),
        .rdValid(link.rdValid), .hardRstN(link.hardRstN),
        .intervalIrq(link.intervalIrq), .chipRst(link.chipRst),
        .rstOutN(link.rstOutN));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ----------------
    // Bus tasks
    // ----------------
    task automatic stop_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task automatic hang(input string m);
        errors++;
        $display("mismatch at %0t: %s timed out", $time, m);
        stop_test();
    endtask : hang

    task automatic chk(input logic [15:0] g, input logic [15:0] e,
                       input string m);
        compares++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    // Request held until waitrequest is seen low at an edge
    task automatic av(input logic w, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= w;
        avsRead <= !w;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avsWaitRequest !== 1'b0 && n < 50);
        q = avsReadData;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        if (n >= 50)
            hang("bus");
        @(posedge clk);
    endtask : av

    task automatic tw(input logic [15:0] a, input logic [15:0] w,
                      input logic word);
        logic [31:0] q;
        av(1'b1, WIT_AV_WDATA, {16'h0000, w}, q);
        av(1'b1, WIT_AV_CMD, {14'h0000, word, 1'b1, a}, q);
    endtask : tw

    task automatic tr(input logic [15:0] a, input logic word,
                      input logic [15:0] e);
        logic [31:0] q;
        int n;
        av(1'b1, WIT_AV_CMD, {14'h0000, word, 1'b0, a}, q);
        n = 0;
        do
        begin
            av(1'b0, WIT_AV_RDATA, 32'h0000_0000, q);
            n++;
        end
        while (q[31] !== 1'b0 && n < 20);
        if (q[31] !== 1'b0)
            hang("read");
        chk(q[15:0], e, "link read");
    endtask : tr

    task automatic wait_pin(input int b, input logic v, input int lim);
        logic [31:0] q;
        int n;
        n = 0;
        do
        begin
            av(1'b0, WIT_AV_PINS, 32'h0000_0000, q);
            n++;
        end
        while (q[b] !== v && n < lim);
        if (q[b] !== v)
            hang("pin");
    endtask : wait_pin

    // ----------------
    // Tests
    // ----------------
    initial
    begin
        logic [31:0] q;
        int k;
        errors = 0;
        compares = 0;
        rst = 1'b1;
        avsAddress = 5'h00;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsWriteData = 32'h0000_0000;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        tr(WIT_ADDR_CSR, 1'b0, 16'h0018);
        tr(WIT_ADDR_CNT, 1'b0, 16'h0000);
        tr(WIT_ADDR_RST, 1'b0, 16'h003f);
        tr(WIT_ADDR_CSR, 1'b1, 16'h1800);
        av(1'b0, 5'h10, 32'h0000_0000, q);
        chk(q[15:0], 16'h0000, "unmapped");
        $display("reset test done");
        tw(WIT_ADDR_CSR, 16'h3327, 1'b1);
        tw(WIT_ADDR_CSR, 16'ha527, 1'b0);
        tw(WIT_ADDR_RST, 16'h5a40, 1'b0);
        tr(WIT_ADDR_CSR, 1'b0, 16'h0018);
        tr(WIT_ADDR_RST, 1'b0, 16'h003f);
        tw(WIT_ADDR_CSR, 16'h5a40, 1'b1);
        tr(WIT_ADDR_CNT, 1'b0, 16'h0000);
        $display("refusal test done");
        // Stop before each select change, as software must
        for (k = 0; k < 8; k++)
        begin
            tw(WIT_ADDR_CSR, {8'ha5, 5'h00, k[2:0]}, 1'b1);
            tw(WIT_ADDR_CSR, {8'ha5, 5'h04, k[2:0]}, 1'b1);
            tw(WIT_ADDR_CSR, 16'h5aff, 1'b1);
            wait_pin(4, 1'b1, 1500);
            av(1'b0, WIT_AV_PINS, 32'h0000_0000, q);
            chk({13'h0000, q[6:4]}, 16'h0001, "interval");
            tw(WIT_ADDR_CSR, {8'ha5, 5'h04, k[2:0]}, 1'b1);
            tr(WIT_ADDR_CSR, 1'b0, {8'h00, 5'h17, k[2:0]});
            tw(WIT_ADDR_CSR, {8'ha5, 5'h00, k[2:0]}, 1'b1);
            tr(WIT_ADDR_CSR, 1'b0, {8'h00, 5'h03, k[2:0]});
        end
        $display("interval test done");
        tw(WIT_ADDR_RST, 16'h5a40, 1'b1);
        tr(WIT_ADDR_RST, 1'b0, 16'h007f);
        tw(WIT_ADDR_CSR, 16'ha560, 1'b1);
        tw(WIT_ADDR_CSR, 16'h5aff, 1'b1);
        wait_pin(5, 1'b1, 20);
        av(1'b0, WIT_AV_PINS, 32'h0000_0000, q);
        chk({13'h0000, q[6:4]}, 16'h0006, "watchdog");
        wait_pin(5, 1'b0, 250);
        tr(WIT_ADDR_RST, 1'b0, 16'h00ff);
        tr(WIT_ADDR_CSR, 1'b0, 16'h0018);
        tw(WIT_ADDR_RST, 16'ha500, 1'b1);
        tr(WIT_ADDR_RST, 1'b0, 16'h007f);
        av(1'b1, WIT_AV_PINS, 32'h0000_0001, q);
        av(1'b1, WIT_AV_PINS, 32'h0000_0000, q);
        tr(WIT_ADDR_RST, 1'b0, 16'h003f);
        // Output enable now clear: the reset must stay inside the chip
        tw(WIT_ADDR_CSR, 16'ha560, 1'b1);
        tw(WIT_ADDR_CSR, 16'h5aff, 1'b1);
        wait_pin(5, 1'b1, 20);
        av(1'b0, WIT_AV_PINS, 32'h0000_0000, q);
        chk({13'h0000, q[6:4]}, 16'h0002, "no pin");
        wait_pin(5, 1'b0, 250);
        tw(WIT_ADDR_RST, 16'ha500, 1'b1);
        $display("watchdog test done");
        tw(WIT_ADDR_CSR, 16'ha521, 1'b1);
        av(1'b1, WIT_AV_PINS, 32'h0000_0004, q);
        tw(WIT_ADDR_CSR, 16'ha501, 1'b1);
        chk({15'h0000, inStandby}, 16'h0000, "refused");
        av(1'b1, WIT_AV_PINS, 32'h0000_0004, q);
        for (k = 0; k < 10 && inStandby !== 1'b1; k++)
            @(posedge clk);
        if (inStandby !== 1'b1)
            hang("standby entry");
        av(1'b1, WIT_AV_PINS, 32'h0000_0008, q);
        for (k = 0; k < 9000 && standbyExit !== 1'b1; k++)
            @(posedge clk);
        if (standbyExit !== 1'b1)
            hang("standby exit");
        tr(WIT_ADDR_CSR, 1'b0, 16'h0019);
        av(1'b1, WIT_AV_PINS, 32'h0000_0002, q);
        av(1'b1, WIT_AV_PINS, 32'h0000_0000, q);
        tr(WIT_ADDR_CSR, 1'b0, 16'h0018);
        $display("standby test done");
        stop_test();
    end
endmodule : watchdog_interval_timer_tb

// file: testbench/wit_link_monitor.sv
// Checker for the timer link; sees the link signals only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module wit_link_monitor
    import wit_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] addr,
    input wire logic wordAcc,
    input wire logic rd,
    input wire logic [15:0] rdData,
    input wire logic rdValid,
    input wire logic hardRstN,
    input wire logic intervalIrq,
    input wire logic chipRst,
    input wire logic rstOutN
);
    // ----------------
    // Pulse counters
    // ----------------
    logic [9:0] chipCnt_q;
    logic [7:0] outCnt_q;

    // Both restart on reset so a cut pulse is never measured
    always_ff @(posedge clk)
    begin
        chipCnt_q <= (chipRst && !rst) ? chipCnt_q + 10'h001 : 10'h000;
        outCnt_q <= (!rstOutN && !rst) ? outCnt_q + 8'h01 : 8'h00;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ----------------
    // Properties
    // ----------------
    property p_rd_answer; rd |=> rdValid; endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered next cycle");
    property p_csr_ones;
        rdValid && $past(addr) == WIT_ADDR_CSR && !$past(wordAcc)
            |-> rdData[15:8] == 8'h00 && rdData[4:3] == WIT_CSR_ONES;
    endproperty
    a_csr_ones: assert property (p_csr_ones)
        else $error("control byte read has bad fixed bits");
    property p_rst_ones;
        rdValid && $past(addr) == WIT_ADDR_RST && !$past(wordAcc)
            |-> rdData[5:0] == WIT_RST_ONES;
    endproperty
    a_rst_ones: assert property (p_rst_ones)
        else $error("reset status read has bad fixed bits");
    property p_chip_len; $fell(chipRst) |-> chipCnt_q == WIT_INT_RST_CYC;
    endproperty
    a_chip_len: assert property (p_chip_len)
        else $error("internal reset length wrong");
    property p_out_len; $rose(rstOutN) |-> outCnt_q == WIT_OUT_RST_CYC;
    endproperty
    a_out_len: assert property (p_out_len)
        else $error("reset-out length wrong");
    property p_out_in_chip; !rstOutN |-> chipRst; endproperty
    a_out_in_chip: assert property (p_out_in_chip)
        else $error("reset-out without internal reset");
    property p_irq_cleared; chipRst |=> !intervalIrq; endproperty
    a_irq_cleared: assert property (p_irq_cleared)
        else $error("overflow kept through internal reset");
    property p_hard_rst;
        !hardRstN |=> !intervalIrq && !chipRst && rstOutN;
    endproperty
    a_hard_rst: assert property (p_hard_rst)
        else $error("reset pin did not clear outputs");

    c_irq: cover property ($rose(intervalIrq));
    c_chip: cover property ($rose(chipRst));
    c_out: cover property ($fell(rstOutN));
endmodule : wit_link_monitor
